// File: logic/rcos_divider.sv
// Divider that toggles an output after a programmable number of source ticks.
`timescale 1ns/1ns
`default_nettype none
module rcos_divider (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic tick,
    input wire logic run,
    input wire logic [3:0] half,
    output logic clk_out
);
    // All state of the divider.
    typedef struct packed {
        logic [3:0] cnt;
        logic lvl;
    } rcos_div_t;
    rcos_div_t s_q;
    rcos_div_t s_d;

    // Next state: when not running, park low with count cleared.
    always_comb begin
        s_d = s_q;
        if (!run) begin
            // Parking low avoids a runt pulse on restart.
            s_d.cnt = 4'h0;
            s_d.lvl = 1'b0;
        end else if (tick) begin
            if (s_q.cnt + 4'h1 >= half) begin
                s_d.cnt = 4'h0;
                s_d.lvl = ~s_q.lvl;
            end else begin
                s_d.cnt = s_q.cnt + 4'h1;
            end
        end
    end

    // Register the state.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign clk_out = s_q.lvl;
endmodule
`default_nettype wire

// File: logic/rcos_pkg.sv
// Package with register map, field layout and timing constants of the recovered clock selector.
package rcos_pkg;
    // Word index of the control register; its byte address is four times the index.
    localparam logic [7:0] REG_CTRL_IDX = 8'h17;
    localparam logic [9:0] REG_CTRL_ADDR = {REG_CTRL_IDX, 2'b00};
    // Status register of own choice, index after the control register.
    localparam logic [7:0] REG_STAT_IDX = 8'h18;
    localparam logic [9:0] REG_STAT_ADDR = {REG_STAT_IDX, 2'b00};
    // Field positions of the control register.
    localparam int EN_BIT = 15;
    localparam int SRC_HI = 14;
    localparam int SRC_LO = 11;
    localparam int FRQ_HI = 10;
    localparam int FRQ_LO = 8;
    localparam int SQL_HI = 5;
    localparam int SQL_LO = 4;
    localparam int TYP_HI = 2;
    localparam int TYP_LO = 0;
    // Writable bit mask; reserved bits 7:6 and 3 read as zero.
    localparam logic [15:0] CTRL_WMASK = 16'hFF37;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    // Frequency codes.
    localparam logic [2:0] FRQ_25 = 3'h0;
    localparam logic [2:0] FRQ_125 = 3'h1;
    localparam logic [2:0] FRQ_31P25 = 3'h2;
    // Clock type codes.
    localparam logic [2:0] TYP_SERDES = 3'h0;
    localparam logic [2:0] TYP_CU_RX = 3'h1;
    localparam logic [2:0] TYP_CU_TX = 3'h2;
    // Squelch levels.
    localparam logic [1:0] SQL_FULL = 2'h0;
    localparam logic [1:0] SQL_RELAX = 2'h1;
    localparam logic [1:0] SQL_LINK = 2'h2;
    localparam logic [1:0] SQL_OFF = 2'h3;
    // Number of ports and the highest valid source code.
    localparam int NPORT = 4;
    localparam logic [3:0] SRC_MAX = 4'h3;
    // Half periods in base enable pulses, base rate 250 MHz equivalent ticks.
    localparam logic [3:0] HALF_25 = 4'h5;
    localparam logic [3:0] HALF_125 = 4'h1;
    localparam logic [3:0] HALF_31P25 = 4'h4;
    // Per-port link state carried together.
    typedef struct packed {
        logic link_up;
        logic stable;
        logic master_1000;
        logic mode_10;
        logic eee_on;
        logic lpi_rx;
    } rcos_link_t;
    // AHB-Lite address phase capture.
    typedef struct packed {
        logic pend;
        logic write;
        logic [9:0] addr;
    } rcos_aph_t;
endpackage

// File: logic/rcos_top.sv
// Top of the recovered clock output selector with its AHB-Lite register slave.
// What this block does
// - Output runs only when enable bit set.
// - Enable zero or reset keeps output off.
// - Source field picks port zero to three.
// - Frequency field picks 25, 125, 31.25 MHz.
// - Level 00 squelches down or unstable link.
// - Level 00 squelches master, 10BASE-T, EEE.
// - Level 01 allows master and 10BASE-T.
// - Level 01 keeps clock during received idle.
// - Level 10 squelches only on link down.
// - Level 11 never squelches automatically.
// - Without squelch clock runs on link down.
// - Squelch pin high silences the clock output.
// - Type field picks serdes, copper rx, tx.
`timescale 1ns/1ns
`default_nettype none
module rcos_top (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [3:0] serdes_tick,
    input wire logic [3:0] cu_rx_tick,
    input wire logic [3:0] copper_transmit_clock,
    input wire rcos_pkg::rcos_link_t [3:0] link_state,
    input wire logic squelch_in,
    output logic regen_clock_out_one
);
    // Whole state of the top module.
    typedef struct packed {
        rcos_pkg::rcos_aph_t aph;
        logic [15:0] ctrl;
        logic [31:0] rdata;
        logic [1:0] sq_sync;
        logic [3:0][1:0] tk_sync;
        logic [3:0] tk_prev;
        logic tick;
        logic gate;
        logic out;
    } rcos_st_t;
    rcos_st_t s_q;
    rcos_st_t s_d;

    // Divider output, level clock at the chosen rate.
    logic div_clk;
    // Combinational helpers.
    logic [3:0] src;
    logic [2:0] frq;
    logic [1:0] sql;
    logic [2:0] typ;
    logic [3:0] half;
    logic codes_ok;
    logic squelch;
    logic [3:0] tick_sel;
    rcos_pkg::rcos_link_t ls;

    // Decode of the automatic squelch for a given level and link state.
    function automatic logic auto_squelch(input logic [1:0] lvl, input rcos_pkg::rcos_link_t l);
        logic down;
        logic bad_mode;
        logic eee_block;
        down = !l.link_up || !l.stable;
        bad_mode = l.master_1000 || l.mode_10;
        eee_block = l.eee_on && !l.lpi_rx;
        case (lvl)
            rcos_pkg::SQL_FULL: auto_squelch = down || bad_mode || l.eee_on;
            rcos_pkg::SQL_RELAX: auto_squelch = down || eee_block;
            rcos_pkg::SQL_LINK: auto_squelch = !l.link_up;
            rcos_pkg::SQL_OFF: auto_squelch = 1'b0;
            default: auto_squelch = 1'b1;
        endcase
    endfunction

    // Field extraction from the control register.
    assign src = s_q.ctrl[rcos_pkg::SRC_HI:rcos_pkg::SRC_LO];
    assign frq = s_q.ctrl[rcos_pkg::FRQ_HI:rcos_pkg::FRQ_LO];
    assign sql = s_q.ctrl[rcos_pkg::SQL_HI:rcos_pkg::SQL_LO];
    assign typ = s_q.ctrl[rcos_pkg::TYP_HI:rcos_pkg::TYP_LO];

    // Frequency decode to a half period, and validity of all codes.
    always_comb begin
        half = rcos_pkg::HALF_25;
        codes_ok = (src <= rcos_pkg::SRC_MAX) && (typ <= rcos_pkg::TYP_CU_TX);
        case (frq)
            rcos_pkg::FRQ_25: half = rcos_pkg::HALF_25;
            rcos_pkg::FRQ_125: half = rcos_pkg::HALF_125;
            rcos_pkg::FRQ_31P25: half = rcos_pkg::HALF_31P25;
            default: codes_ok = 1'b0;
        endcase
    end

    // Source type selects which tick vector feeds the divider.
    always_comb begin
        case (typ)
            rcos_pkg::TYP_SERDES: tick_sel = serdes_tick;
            rcos_pkg::TYP_CU_RX: tick_sel = cu_rx_tick;
            rcos_pkg::TYP_CU_TX: tick_sel = copper_transmit_clock;
            default: tick_sel = 4'h0;
        endcase
    end

    // Link state of the chosen port; out-of-range source reads the port of its low two bits but codes_ok blocks it.
    assign ls = link_state[src[1:0]];
    assign squelch = s_q.sq_sync[1] || auto_squelch(sql, ls);

    // Next state: bus slave, synchronisers, edge detect and output gating.
    always_comb begin
        s_d = s_q;
        // Squelch pin passes two flops before use.
        s_d.sq_sync = {s_q.sq_sync[0], squelch_in};
        // Synchronise the ticks of all ports and detect the rising edge of the chosen one.
        for (int i = 0; i < rcos_pkg::NPORT; i++) begin
            s_d.tk_sync[i] = {s_q.tk_sync[i][0], tick_sel[i]};
            s_d.tk_prev[i] = s_q.tk_sync[i][1];
        end
        s_d.tick = s_q.tk_sync[src[1:0]][1] && !s_q.tk_prev[src[1:0]];
        // Gate only turns on while the divider is low, so no partial pulse appears at start.
        if (!div_clk) begin
            s_d.gate = s_q.ctrl[rcos_pkg::EN_BIT] && codes_ok && !squelch;
        end
        // A reserved code cuts at once as well; a silent tick source would otherwise freeze a high level.
        if (squelch || !s_q.ctrl[rcos_pkg::EN_BIT] || !codes_ok) begin
            s_d.gate = 1'b0;
        end
        s_d.out = s_q.gate && div_clk;
        // Data phase of a captured write.
        if (s_q.aph.pend && s_q.aph.write) begin
            if (s_q.aph.addr == rcos_pkg::REG_CTRL_ADDR) begin
                s_d.ctrl = hwdata[15:0] & rcos_pkg::CTRL_WMASK;
            end
        end
        // Address phase capture; unmapped reads return zero.
        s_d.aph.pend = 1'b0;
        if (hsel && hready && htrans[1]) begin
            s_d.aph.pend = 1'b1;
            s_d.aph.write = hwrite;
            s_d.aph.addr = haddr[9:0];
            if (haddr[9:0] == rcos_pkg::REG_CTRL_ADDR) begin
                s_d.rdata = {16'h0000, s_q.ctrl};
            end else if (haddr[9:0] == rcos_pkg::REG_STAT_ADDR) begin
                s_d.rdata = {28'h000_0000, codes_ok, squelch, s_q.sq_sync[1], s_q.gate};
            end else begin
                s_d.rdata = 32'h0000_0000;
            end
        end
    end

    // Register the state.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
            s_q.ctrl <= rcos_pkg::CTRL_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // Divider runs only while gated on.
    rcos_divider u_div (
        .mclk(mclk),
        .reset_n(reset_n),
        .tick(s_q.tick),
        .run(s_q.gate),
        .half(half),
        .clk_out(div_clk)
    );

    assign hrdata = s_q.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign regen_clock_out_one = s_q.out;
endmodule
`default_nettype wire

// File: sim/rcos_chk.sv
// Port checker for the recovered clock selector, bound to its top module.
`timescale 1ns/1ns
`default_nettype none
module rcos_chk (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire rcos_pkg::rcos_link_t [3:0] link_state,
    input wire logic squelch_in,
    input wire logic regen_clock_out_one
);
    logic wr_q; // A write address phase was taken last cycle.
    logic [9:0] wa_q; // Byte address of that write.
    logic [15:0] ctl_q; // Mirror of the control register.
    rcos_pkg::rcos_link_t ls; // Link state of the selected port.
    assign ls = link_state[ctl_q[12:11]];
    // Mirror control writes at the end of their data phase.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wr_q <= 1'b0;
            wa_q <= 10'h000;
            ctl_q <= 16'h0000;
        end else begin
            wr_q <= hsel && hready && htrans[1] && hwrite;
            wa_q <= haddr[9:0];
            if (wr_q && wa_q == rcos_pkg::REG_CTRL_ADDR) begin
                ctl_q <= hwdata[15:0] & rcos_pkg::CTRL_WMASK;
            end
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // A cause held long enough to pass the synchronisers.
    sequence held(b);
        b [*6];
    endsequence
    // The output sits low after a held cause.
    property low_after(b);
        held(b) |-> !regen_clock_out_one;
    endproperty
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not okay");
    a_rise_enabled: assert property ($rose(regen_clock_out_one) |-> $past(ctl_q[15]))
        else $error("clock rose while disabled");
    a_enable_off: assert property (low_after(!ctl_q[15]))
        else $error("clock while disabled");
    a_pin_squelch: assert property (low_after(squelch_in))
        else $error("clock while squelch pin high");
    a_bad_source: assert property (low_after(ctl_q[14:11] > 4'h3))
        else $error("clock from reserved source");
    a_bad_freq: assert property (low_after(ctl_q[10:8] > 3'h2))
        else $error("clock at reserved rate");
    a_bad_type: assert property (low_after(ctl_q[2:0] > 3'h2))
        else $error("clock of reserved type");
    a_link_down: assert property (low_after(ctl_q[5:4] != 2'h3 && !ls.link_up))
        else $error("clock with link down");
    a_full_level: assert property (low_after(ctl_q[5:4] == 2'h0 &&
        (!ls.stable || ls.master_1000 || ls.mode_10 || ls.eee_on)))
        else $error("clock in unsupported mode");
    a_relax_eee: assert property (low_after(ctl_q[5:4] == 2'h1 && ls.eee_on && !ls.lpi_rx))
        else $error("clock in idle-less energy mode");
endmodule
bind rcos_top rcos_chk i_rcos_chk (.mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .link_state(link_state), .squelch_in(squelch_in),
    .regen_clock_out_one(regen_clock_out_one));
`default_nettype wire

// File: sim/rcos_far.sv
// Timing device model that counts and times rising edges of the recovered clock.
`timescale 1ns/1ns
`default_nettype none
module rcos_far (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic clk_in,
    output logic [15:0] rises,
    output logic [15:0] period
);
    logic prev_q; // Clock level one cycle ago.
    logic [15:0] cnt_q; // Cycles since the last rising edge.
    // Count edges and keep the spacing of the last two.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            prev_q <= 1'b0;
            cnt_q <= 16'h0000;
            rises <= 16'h0000;
            period <= 16'h0000;
        end else begin
            prev_q <= clk_in;
            cnt_q <= cnt_q + 16'h0001;
            if (clk_in && !prev_q) begin
                rises <= rises + 16'h0001;
                period <= cnt_q;
                cnt_q <= 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// File: sim/rcos_top_test.sv
// Self-checking testbench of the recovered clock selector.
`timescale 1ns/1ns
`default_nettype none
module rcos_top_test;
    logic mclk, reset_n, hsel, hwrite, hreadyout, hresp, squelch_in, clk_o;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] serdes_tick, cu_rx_tick, cu_tx_tick;
    rcos_pkg::rcos_link_t [3:0] link_state;
    logic [15:0] rises, period;
    int cyc, miscompares, check_count;
    rcos_top i_rcos_top (.mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .serdes_tick(serdes_tick),
        .cu_rx_tick(cu_rx_tick), .copper_transmit_clock(cu_tx_tick), .link_state(link_state),
        .squelch_in(squelch_in), .regen_clock_out_one(clk_o));
    rcos_far i_rcos_far (.mclk(mclk), .reset_n(reset_n), .clk_in(clk_o), .rises(rises),
        .period(period));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Each source toggles every T cycles, T = port + 1 + 4 * type, so selection shows in rate.
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        for (int p = 0; p < 4; p++) begin
            serdes_tick[p] <= 1'((cyc / (p + 1)) % 2);
            cu_rx_tick[p] <= 1'((cyc / (p + 5)) % 2);
            cu_tx_tick[p] <= 1'((cyc / (p + 9)) % 2);
        end
        if (cyc > 60000) begin
            // Counted at once so that the verdict below already sees the timeout.
            miscompares++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One AHB-Lite single word transfer; waits on hready in both phases.
    task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {22'h00_0000, a};
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        rd = hrdata;
    endtask
    task automatic t_regs();
        bus(1'b0, rcos_pkg::REG_CTRL_ADDR, 32'h0000_0000);
        chk("ctrl reset", 32'h0000_0000, rd);
        bus(1'b1, rcos_pkg::REG_CTRL_ADDR, 32'hFFFF_FFFF);
        bus(1'b0, rcos_pkg::REG_CTRL_ADDR, 32'h0000_0000);
        chk("ctrl mask", 32'h0000_FF37, rd);
        bus(1'b0, 10'h3FC, 32'h0000_0000);
        chk("unmapped", 32'h0000_0000, rd);
    endtask
    // Every source, type and rate with links down and squelch off.
    task automatic t_rates();
        logic [3:0] hf [3];
        hf = '{4'h5, 4'h1, 4'h4};
        for (int s = 0; s < 4; s++) for (int t = 0; t < 3; t++) for (int f = 0; f < 3; f++) begin
            bus(1'b1, rcos_pkg::REG_CTRL_ADDR, 32'h0000_8030 | (s << 11) | (f << 8) | t);
            repeat (700) @(posedge mclk);
            chk("period", 4 * hf[f] * (s + 1 + 4 * t), {16'h0000, period});
        end
    endtask
    // Runs or stays silent under one control value, link state and pin level.
    task automatic run(input logic [15:0] c, input logic [5:0] lk, input logic pin, input logic e);
        logic [15:0] r0;
        link_state <= {4{lk}};
        squelch_in <= pin;
        bus(1'b1, rcos_pkg::REG_CTRL_ADDR, {16'h0000, c});
        repeat (50) @(posedge mclk);
        r0 = rises;
        repeat (100) @(posedge mclk);
        chk("running", {31'h0000_0000, e}, {31'h0000_0000, rises != r0});
    endtask
    initial begin
        {reset_n, hsel, hwrite, squelch_in, haddr, hwdata, htrans} = '0;
        {cyc, miscompares, check_count, link_state} = '0;
        hsize = 3'h2;
        repeat (10) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        t_regs();
        t_rates();
        run(16'h8100, 6'h30, 1'b0, 1'b1);
        run(16'h8100, 6'h38, 1'b0, 1'b0);
        run(16'h8100, 6'h32, 1'b0, 1'b0);
        run(16'h8100, 6'h20, 1'b0, 1'b0);
        run(16'h8110, 6'h34, 1'b0, 1'b1);
        run(16'h8110, 6'h33, 1'b0, 1'b1);
        run(16'h8120, 6'h20, 1'b0, 1'b1);
        run(16'h8120, 6'h00, 1'b0, 1'b0);
        run(16'h8130, 6'h30, 1'b1, 1'b0);
        run(16'h0130, 6'h30, 1'b0, 1'b0);
        run(16'hA130, 6'h30, 1'b0, 1'b0);
        run(16'h8330, 6'h30, 1'b0, 1'b0);
        run(16'h8133, 6'h30, 1'b0, 1'b0);
        summarize();
    end
endmodule
`default_nettype wire
